/* File: lfm_fault_manager.sv */
// Fault supervisor of a boost LED driver with an APB register slave.
`timescale 1ns/1ns
`include "lfm_consts.svh"

module lfm_fault_manager #(
  parameter int unsigned RECOVERY_CYC = `LFM_RECOVERY_CYC,
  parameter int unsigned BST_OCP_CYC  = `LFM_BST_OCP_CYC
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_srst,
  input  wire logic                      i_psel,
  input  wire logic                      i_penable,
  input  wire logic                      i_pwrite,
  input  wire logic [11:0]               i_paddr,
  input  wire logic [31:0]               i_pwdata,
  output logic      [31:0]               o_prdata,
  output logic                           o_pready,
  output logic                           o_pslverr,
  input  wire logic                      i_enable,
  input  wire logic                      i_brightness_nonzero,
  input  wire logic                      i_boost_sync_input,
  input  wire logic                      i_init_done,
  input  wire lfm_pkg::lfm_fault_in_type i_fault,
  output lfm_pkg::lfm_control_type       o_control,
  output lfm_pkg::lfm_state_type         o_state,
  output logic                           o_irq
);
  import lfm_pkg::*;

  localparam int NF = `LFM_NUM_FLAGS;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  lfm_state_type   state;
  lfm_state_type   next_state;
  logic [NF-1:0]   status;
  logic [NF-1:0]   mask;
  logic [NF-1:0]   events;
  logic [NF-1:0]   level;
  logic [NF-1:0]   level_q;
  logic [31:0]     timer;
  logic [31:0]     ocp_count;
  logic            ocp_trip;
  logic            recover_req;
  logic            standby_req;
  logic            timer_done;
  logic            sync_fallback;
  logic            ledset_bad;
  logic            modesel_bad;
  logic            boost_frequency_resistor_bad;
  logic            dimming_frequency_resistor_bad;
  logic            wr_access;
  logic            rd_access;
  logic            addr_ok;
  logic [NF-1:0]   w1c;

  // ****************************************************************
  // Fault levels and rising-edge events
  // ****************************************************************
  always_comb begin
    level                         = '0;
    level[`LFM_BIT_VIN_UV]        = i_fault.vin_uv;
    level[`LFM_BIT_VIN_OV]        = i_fault.vin_ov;
    level[`LFM_BIT_VDD_UV]        = i_fault.vdd_uv;
    level[`LFM_BIT_VIN_OC]        = i_fault.vin_oc;
    level[`LFM_BIT_CP_FAULT]      = i_fault.cp_fault
                                    | i_fault.cp_missing;
    level[`LFM_BIT_CP_MISSING]    = i_fault.cp_missing;
    level[`LFM_BIT_SYNC_LOST]     = i_fault.sync_lost;
    level[`LFM_BIT_CRC_ERR]       = i_fault.crc_err;
    level[`LFM_BIT_BST_OVP_LOW]   = i_fault.bst_ovp_low;
    level[`LFM_BIT_BST_OVP_HIGH]  = i_fault.bst_ovp_high;
    level[`LFM_BIT_BST_OCP]       = ocp_trip;
    level[`LFM_BIT_LEDSET]        = ledset_bad;
    level[`LFM_BIT_MODESEL]       = modesel_bad;
    level[`LFM_BIT_FSET]          = boost_frequency_resistor_bad | dimming_frequency_resistor_bad;
  end

  assign events = level & ~level_q;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      level_q <= '0;
    end else begin
      level_q <= level;
    end
  end

  // ****************************************************************
  // Boost overcurrent timer
  // ****************************************************************
  // Counts only while the boost is running, since the feedback node is
  // expected to sit low when the converter is off.
  always_ff @(posedge i_clk) begin
    if (i_srst || !i_fault.fb_below_uvp || state != LFM_RUN) begin
      ocp_count <= '0;
      ocp_trip  <= 1'b0;
    end else if (ocp_count >= BST_OCP_CYC - 1) begin
      ocp_trip  <= 1'b1;
    end else begin
      ocp_count <= ocp_count + 32'h1;
    end
  end

  // ****************************************************************
  // Setting resistor results, caught when initialisation completes
  // ****************************************************************
  // Resistors are only judged once, so a later change has no effect.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ledset_bad   <= 1'b0;
      modesel_bad  <= 1'b0;
      boost_frequency_resistor_bad <= 1'b0;
      dimming_frequency_resistor_bad <= 1'b0;
    end else if (state == LFM_INIT && i_init_done) begin
      ledset_bad   <= i_fault.ledset_bad;
      modesel_bad  <= i_fault.modesel_bad;
      boost_frequency_resistor_bad <= i_fault.boost_frequency_resistor_bad;
      dimming_frequency_resistor_bad <= i_fault.dimming_frequency_resistor_bad;
    end
  end

  // ****************************************************************
  // Sync clock fallback
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (i_srst || !i_enable) begin
      sync_fallback <= 1'b0;
    end else if (i_fault.sync_lost) begin
      sync_fallback <= 1'b1;
    end
  end

  // ****************************************************************
  // Operating state machine
  // ****************************************************************
  assign recover_req = i_fault.vin_oc | i_fault.cp_fault
                     | i_fault.bst_ovp_high | ocp_trip;
  assign standby_req = i_fault.vin_uv | i_fault.vin_ov
                     | i_fault.vdd_uv;
  assign timer_done  = (timer >= RECOVERY_CYC - 1);

  always_comb begin
    next_state = state;
    unique case (state)
      LFM_INIT: begin
        if (i_init_done) begin
          next_state = LFM_STANDBY;
        end
      end
      LFM_STANDBY: begin
        if (i_enable && !standby_req && !recover_req) begin
          next_state = LFM_RUN;
        end
      end
      LFM_RUN: begin
        if (!i_enable || standby_req) begin
          next_state = LFM_STANDBY;
        end else if (recover_req) begin
          next_state = LFM_RECOVERY;
        end
      end
      LFM_RECOVERY: begin
        // The high boost overvoltage must also have fallen away.
        if (timer_done && !i_fault.bst_ovp_high) begin
          next_state = LFM_HOLD;
        end
      end
      LFM_HOLD: begin
        if (!i_enable) begin
          next_state = LFM_STANDBY;
        end else if (i_brightness_nonzero) begin
          next_state = LFM_STANDBY;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state <= LFM_INIT;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst || state != LFM_RECOVERY) begin
      timer <= '0;
    end else if (!timer_done) begin
      timer <= timer + 32'h1;
    end
  end

  // ****************************************************************
  // Control outputs
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_control <= '0;
    end else begin
      o_control.led_enable         <= (state == LFM_RUN)
                                      && i_brightness_nonzero;
      o_control.boost_enable       <= (state == LFM_RUN);
      o_control.boost_switch       <= (state == LFM_RUN)
                                      && !i_fault.bst_ovp_low;
      o_control.pl_switch_enable   <= (state == LFM_RUN);
      o_control.charge_pump_enable <= !i_fault.cp_missing;
      o_control.use_internal_clock <= sync_fallback;
      o_control.spread_spectrum    <= sync_fallback
                                      && i_boost_sync_input;
      o_control.led_cfg_default    <= ledset_bad;
      o_control.led_channels       <= `LFM_DEF_LED_CHANNELS;
      o_control.led_current_ma     <= `LFM_DEF_LED_CURRENT_MA;
      o_control.mode_default       <= modesel_bad;
      o_control.phase_shift_pwm    <= 1'b1;
      o_control.i2c_addr           <= `LFM_DEF_I2C_ADDR;
      o_control.boost_freq_default <= boost_frequency_resistor_bad;
      o_control.boost_khz          <= `LFM_DEF_BOOST_KHZ;
      o_control.dim_freq_default   <= dimming_frequency_resistor_bad;
      o_control.dim_hz             <= `LFM_DEF_DIM_HZ;
    end
  end

  assign o_state = state;

  // ****************************************************************
  // Status, mask and interrupt
  // ****************************************************************
  assign wr_access = i_psel && i_penable && i_pwrite;
  assign rd_access = i_psel && i_penable && !i_pwrite;
  assign w1c = (wr_access && i_paddr == `LFM_ADDR_STATUS)
             ? i_pwdata[NF-1:0] : '0;

  // A new event in the clearing cycle wins over the clear.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      status <= '0;
    end else begin
      status <= (status & ~w1c) | events;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      mask <= `LFM_MASK_RESET;
    end else if (wr_access && i_paddr == `LFM_ADDR_MASK) begin
      mask <= i_pwdata[NF-1:0];
    end
  end

  // Flags that carry no interrupt are left out of the output.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(status & mask & `LFM_IRQ_CAPABLE);
    end
  end

  // ****************************************************************
  // APB read path
  // ****************************************************************
  assign addr_ok = (i_paddr == `LFM_ADDR_STATUS)
                || (i_paddr == `LFM_ADDR_MASK)
                || (i_paddr == `LFM_ADDR_STATE)
                || (i_paddr == `LFM_ADDR_CONFIG);
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && !addr_ok;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_prdata <= '0;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      unique case (i_paddr)
        `LFM_ADDR_STATUS: o_prdata <= {18'h0, status};
        `LFM_ADDR_MASK:   o_prdata <= {18'h0, mask};
        `LFM_ADDR_STATE:  o_prdata <= {29'h0, state};
        `LFM_ADDR_CONFIG: o_prdata <= {26'h0, sync_fallback,
                                       o_control.spread_spectrum,
                                       dimming_frequency_resistor_bad, boost_frequency_resistor_bad,
                                       modesel_bad, ledset_bad};
        default:          o_prdata <= 32'h0;
      endcase
    end
  end

endmodule : lfm_fault_manager

/* File: lfm_consts.svh */
// Constants for the LED driver fault manager: offsets, fields, timings.
`ifndef LFM_CONSTS_SVH
`define LFM_CONSTS_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define LFM_ADDR_STATUS        12'h000
`define LFM_ADDR_MASK          12'h004
`define LFM_ADDR_STATE         12'h008
`define LFM_ADDR_CONFIG        12'h00C

// ****************************************************************
// Status bit positions
// ****************************************************************
`define LFM_BIT_VIN_UV         0
`define LFM_BIT_VIN_OV         1
`define LFM_BIT_VDD_UV         2
`define LFM_BIT_VIN_OC         3
`define LFM_BIT_CP_FAULT       4
`define LFM_BIT_CP_MISSING     5
`define LFM_BIT_SYNC_LOST      6
`define LFM_BIT_CRC_ERR        7
`define LFM_BIT_BST_OVP_LOW    8
`define LFM_BIT_BST_OVP_HIGH   9
`define LFM_BIT_BST_OCP        10
`define LFM_BIT_LEDSET         11
`define LFM_BIT_MODESEL        12
`define LFM_BIT_FSET           13
`define LFM_NUM_FLAGS          14

// Flags that may raise the interrupt; the others never do.
`define LFM_IRQ_CAPABLE        14'h06FF
`define LFM_MASK_RESET         14'h3FFF

// ****************************************************************
// Defaults on a bad setting resistor
// ****************************************************************
`define LFM_DEF_LED_CHANNELS   3'h4
`define LFM_DEF_LED_CURRENT_MA 8'hC8
`define LFM_DEF_I2C_ADDR       7'h3A
`define LFM_DEF_BOOST_KHZ      12'h190
`define LFM_DEF_DIM_HZ         12'h131

// ****************************************************************
// Timing
// ****************************************************************
`define LFM_CLK_HZ             125000000
`define LFM_RECOVERY_MS        100
`define LFM_BST_OCP_MS         110
`define LFM_RECOVERY_CYC       ((`LFM_CLK_HZ / 1000) * `LFM_RECOVERY_MS)
`define LFM_BST_OCP_CYC        ((`LFM_CLK_HZ / 1000) * `LFM_BST_OCP_MS)

`endif

/* File: lfm_pkg.sv */
// Types for the LED driver fault manager.
package lfm_pkg;

  typedef enum logic [2:0] {
    LFM_INIT,
    LFM_STANDBY,
    LFM_RUN,
    LFM_RECOVERY,
    LFM_HOLD
  } lfm_state_type;

  // Fault detector inputs, all synchronous active-high levels.
  typedef struct packed {
    logic vin_uv;
    logic vin_ov;
    logic vdd_uv;
    logic vin_oc;
    logic cp_fault;
    logic cp_missing;
    logic sync_lost;
    logic crc_err;
    logic bst_ovp_low;
    logic bst_ovp_high;
    logic fb_below_uvp;
    logic ledset_bad;
    logic modesel_bad;
    logic boost_frequency_resistor_bad;
    logic dimming_frequency_resistor_bad;
  } lfm_fault_in_type;

  // Power stage enables and fallback settings.
  typedef struct packed {
    logic        led_enable;
    logic        boost_enable;
    logic        boost_switch;
    logic        pl_switch_enable;
    logic        charge_pump_enable;
    logic        use_internal_clock;
    logic        spread_spectrum;
    logic        led_cfg_default;
    logic [2:0]  led_channels;
    logic [7:0]  led_current_ma;
    logic        mode_default;
    logic        phase_shift_pwm;
    logic [6:0]  i2c_addr;
    logic        boost_freq_default;
    logic [11:0] boost_khz;
    logic        dim_freq_default;
    logic [11:0] dim_hz;
  } lfm_control_type;

endpackage : lfm_pkg

/* File: lfm_fault_manager_assertions.sv */
// Port-level checks for the LED driver fault manager.
`timescale 1ns/1ns
`include "lfm_consts.svh"
module lfm_fault_manager_assertions
  import lfm_pkg::*;
#(
  parameter int unsigned RECOVERY_CYC = 20,
  parameter int unsigned BST_OCP_CYC  = 30
) (
  input wire logic                      i_clk,
  input wire logic                      i_srst,
  input wire logic                      i_enable,
  input wire lfm_pkg::lfm_fault_in_type i_fault,
  input wire lfm_pkg::lfm_control_type  o_control,
  input wire lfm_pkg::lfm_state_type    o_state
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  logic [31:0] rec_cnt;
  logic [31:0] fb_cnt;
  logic        in_bad;
  logic        run_ok;

  assign in_bad = i_fault.vin_uv | i_fault.vin_ov | i_fault.vdd_uv;
  assign run_ok = (o_state == LFM_RUN) && i_enable && !in_bad;

  // Cycles spent in recovery, and low-feedback cycles in a row while running.
  always_ff @(posedge i_clk) begin
    if (i_srst || o_state != LFM_RECOVERY) begin
      rec_cnt <= 32'h0;
    end else begin
      rec_cnt <= rec_cnt + 32'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst || o_state != LFM_RUN || !i_fault.fb_below_uvp) begin
      fb_cnt <= 32'h0;
    end else begin
      fb_cnt <= fb_cnt + 32'h1;
    end
  end

  // ************
  // Properties
  // ************
  property p_to_standby;
    o_state == LFM_RUN && in_bad |-> ##[1:2] o_state == LFM_STANDBY;
  endproperty
  a_to_standby: assert property (p_to_standby)
    else $error("run kept despite input fault");
  property p_oc_rec;
    run_ok && (i_fault.vin_oc || i_fault.cp_fault)
      |-> ##[1:2] o_state == LFM_RECOVERY;
  endproperty
  a_oc_rec: assert property (p_oc_rec)
    else $error("no recovery on overcurrent or pump fault");
  property p_ovph_rec;
    run_ok && i_fault.bst_ovp_high |-> ##[1:2] o_state == LFM_RECOVERY;
  endproperty
  a_ovph_rec: assert property (p_ovph_rec)
    else $error("no recovery on boost overvoltage");
  property p_rec_len;
    rec_cnt != 32'h0 && o_state != LFM_RECOVERY
      |-> rec_cnt >= RECOVERY_CYC && o_state == LFM_HOLD;
  endproperty
  a_rec_len: assert property (p_rec_len)
    else $error("recovery too short");
  property p_rec_off;
    o_state == LFM_RECOVERY && rec_cnt != 32'h0 |-> !o_control.led_enable
      && !o_control.boost_enable && !o_control.pl_switch_enable;
  endproperty
  a_rec_off: assert property (p_rec_off)
    else $error("power stage on in recovery");
  property p_ocp;
    fb_cnt == BST_OCP_CYC + 2 |-> o_state != LFM_RUN;
  endproperty
  a_ocp: assert property (p_ocp)
    else $error("boost overcurrent not acted on");
  property p_ovpl;
    (o_state == LFM_RUN && i_fault.bst_ovp_low) [*3]
      |-> !o_control.boost_switch;
  endproperty
  a_ovpl: assert property (p_ovpl)
    else $error("boost still switching");
  property p_cpmiss;
    i_fault.cp_missing [*3] |-> !o_control.charge_pump_enable;
  endproperty
  a_cpmiss: assert property (p_cpmiss)
    else $error("charge pump left on");
  property p_led_def;
    o_control.led_cfg_default
      |-> o_control.led_channels == `LFM_DEF_LED_CHANNELS
      && o_control.led_current_ma == `LFM_DEF_LED_CURRENT_MA;
  endproperty
  a_led_def: assert property (p_led_def)
    else $error("led default wrong");
  property p_mode_def;
    o_control.mode_default
      |-> o_control.phase_shift_pwm && o_control.i2c_addr == `LFM_DEF_I2C_ADDR;
  endproperty
  a_mode_def: assert property (p_mode_def)
    else $error("mode default wrong");
  property p_freq_def;
    o_control.boost_freq_default |-> o_control.boost_khz == `LFM_DEF_BOOST_KHZ;
  endproperty
  a_freq_def: assert property (p_freq_def)
    else $error("boost frequency default wrong");
  c_rec: cover property (o_state == LFM_RECOVERY ##1 o_state == LFM_HOLD);
  c_stby: cover property (o_state == LFM_RUN ##1 o_state == LFM_STANDBY);
  c_ovpl: cover property (o_state == LFM_RUN && i_fault.bst_ovp_low);
endmodule : lfm_fault_manager_assertions

bind lfm_fault_manager lfm_fault_manager_assertions #(
  .RECOVERY_CYC(RECOVERY_CYC),
  .BST_OCP_CYC (BST_OCP_CYC)
) lfm_fault_manager_assertions_inst (
  .i_clk(i_clk), .i_srst(i_srst), .i_enable(i_enable),
  .i_fault(i_fault), .o_control(o_control), .o_state(o_state)
);

/* File: lfm_fault_manager_tb.sv */
// Self-checking bench for the LED driver fault manager.
`timescale 1ns/1ns
`include "lfm_consts.svh"
module testbench;
  import lfm_pkg::*;
  typedef struct packed {
    logic [31:0] d;
    logic [31:0] m;
    logic        e;
  } lfm_exp_type;
  localparam int RC  = 20;
  localparam int OCP = 30;
  logic             i_clk = 1'b0;
  logic             i_srst = 1'b1;
  logic             i_psel = 1'b0;
  logic             i_penable = 1'b0;
  logic             i_pwrite = 1'b0;
  logic [11:0]      i_paddr = 12'h0;
  logic [31:0]      i_pwdata = 32'h0;
  logic             i_enable = 1'b0;
  logic             i_brightness_nonzero = 1'b1;
  logic             i_boost_sync_input = 1'b0;
  logic             i_init_done = 1'b0;
  logic [31:0]      o_prdata;
  logic             o_pready, o_pslverr, o_irq;
  lfm_fault_in_type i_fault;
  lfm_control_type  o_control;
  lfm_state_type    o_state, want;
  lfm_exp_type      exp_q[$];
  lfm_exp_type      got;
  int               bad_count = 0;
  int               n_compared = 0;
  logic [31:0]      r;
  logic [13:0]      sb;
  time              t0;

  lfm_fault_manager #(.RECOVERY_CYC(RC), .BST_OCP_CYC(OCP))
    lfm_fault_manager_inst (
    .i_clk(i_clk), .i_srst(i_srst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_enable(i_enable), .i_brightness_nonzero(i_brightness_nonzero),
    .i_boost_sync_input(i_boost_sync_input), .i_init_done(i_init_done),
    .i_fault(i_fault), .o_control(o_control), .o_state(o_state),
    .o_irq(o_irq));

  always #4 i_clk = ~i_clk;

  // ************
  // Tasks
  // ************
  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd, input lfm_exp_type x);
    int n;
    n = 0;
    @(posedge i_clk);
    exp_q.push_back(x);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= wd;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    chk(n < 20, "no ready");
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] d,
                    input logic [31:0] m);
    apb(1'b0, a, 32'h0, '{d, m, 1'b0});
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, '{32'h0, 32'h0, 1'b0});
  endtask : wr

  task automatic wait_st(input lfm_state_type s, input int lim);
    int n;
    n = 0;
    @(negedge i_clk);
    while (o_state !== s && n < lim) begin
      @(negedge i_clk);
      n++;
    end
    chk(o_state === s, "state not reached");
  endtask : wait_st

  // Compares every bus answer with the oldest expectation.
  always @(posedge i_clk) begin
    if (i_psel && i_penable && o_pready === 1'b1) begin
      got = exp_q.pop_front();
      chk((o_prdata & got.m) === (got.d & got.m) && o_pslverr === got.e,
          "bus answer");
    end
  end

  initial begin
    #(8 * 20000);
    bad_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    summarize();
  end

  // ************
  // Scenarios
  // ************
  initial begin
    r = $urandom(32'h4bc59d4d);
    i_fault = 15'h000F;
    repeat (3) @(posedge i_clk);
    i_srst <= 1'b0;
    rd(`LFM_ADDR_MASK, `LFM_MASK_RESET, '1);
    rd(`LFM_ADDR_STATUS, 32'h0, '1);
    chk(o_state === LFM_INIT && o_irq === 1'b0, "reset outputs");
    i_init_done <= 1'b1;
    wait_st(LFM_STANDBY, 20);
    @(posedge i_clk);
    i_fault <= '0;
    repeat (3) @(negedge i_clk);
    chk(o_control.led_channels === `LFM_DEF_LED_CHANNELS, "chan");
    chk(o_control.led_current_ma === `LFM_DEF_LED_CURRENT_MA, "ma");
    chk(o_control.i2c_addr === `LFM_DEF_I2C_ADDR, "addr");
    chk(o_control.phase_shift_pwm === 1'b1, "pwm mode");
    chk(o_control.boost_khz === `LFM_DEF_BOOST_KHZ, "boost");
    chk(o_control.dim_hz === `LFM_DEF_DIM_HZ, "dim");
    chk(o_irq === 1'b0, "resistor irq");
    rd(`LFM_ADDR_STATUS, 32'h3800, '1);
    rd(`LFM_ADDR_CONFIG, 32'hF, 32'hF);
    wr(`LFM_ADDR_STATUS, 32'h3FFF);
    rd(`LFM_ADDR_STATUS, 32'h0, '1);
    apb(1'b0, 12'h010, 32'h0, '{32'h0, '1, 1'b1});
    apb(1'b1, 12'h010, r, '{32'h0, 32'h0, 1'b1});
    r = $urandom & 32'h3FFF;
    wr(`LFM_ADDR_MASK, r);
    rd(`LFM_ADDR_MASK, r, '1);
    wr(`LFM_ADDR_MASK, 32'h0);
    i_fault.crc_err <= 1'b1;
    repeat (5) @(negedge i_clk);
    chk(o_irq === 1'b0, "masked irq");
    wr(`LFM_ADDR_MASK, 32'h80);
    repeat (3) @(negedge i_clk);
    chk(o_irq === 1'b1, "unmasked irq");
    @(posedge i_clk);
    i_fault.crc_err <= 1'b0;
    wr(`LFM_ADDR_STATUS, 32'h80);
    repeat (3) @(negedge i_clk);
    chk(o_irq === 1'b0, "irq not cleared");
    wr(`LFM_ADDR_MASK, 32'h3FFF);
    i_enable <= 1'b1;
    wait_st(LFM_RUN, 50);
    for (int i = 14; i >= 5; i--) begin
      sb = 14'h1 << (14 - i);
      if (i == 9) sb = sb | 14'h0010;
      want = (i >= 12) ? LFM_STANDBY :
             (i == 11 || i == 10 || i == 5) ? LFM_RECOVERY : LFM_RUN;
      @(posedge i_clk);
      i_boost_sync_input <= 1'($urandom);
      i_fault[i] <= 1'b1;
      t0 = $time;
      repeat (5) @(negedge i_clk);
      chk(o_state === want, "fault state");
      chk(o_irq === |(sb & `LFM_IRQ_CAPABLE), "irq");
      if (want == LFM_RECOVERY) chk({o_control.led_enable,
        o_control.boost_enable, o_control.pl_switch_enable} === 3'h0,
        "stage on");
      if (i == 9) chk(o_control.charge_pump_enable === 1'b0, "cp");
      if (i == 6) chk(o_control.boost_switch === 1'b0, "switching");
      if (i == 8) begin
        chk(o_control.use_internal_clock === 1'b1, "no fallback");
        @(posedge i_clk);
        i_boost_sync_input <= 1'b1;
        repeat (3) @(negedge i_clk);
        chk(o_control.spread_spectrum === 1'b1, "spread off");
        @(posedge i_clk);
        i_boost_sync_input <= 1'b0;
        repeat (3) @(negedge i_clk);
        chk(o_control.spread_spectrum === 1'b0, "spread on");
      end
      rd(`LFM_ADDR_STATUS, {18'h0, sb}, '1);
      i_fault[i] <= 1'b0;
      if (want == LFM_RECOVERY) begin
        for (int k = 0; k < 99 && o_state === LFM_RECOVERY; k++)
          @(negedge i_clk);
        chk(($time - t0) / 8 >= RC && ($time - t0) / 8 <= RC + 5,
            "recovery time");
      end
      wait_st(LFM_RUN, 3 * RC);
      rd(`LFM_ADDR_STATUS, {18'h0, sb}, '1);
      wr(`LFM_ADDR_STATUS, {18'h0, sb});
      rd(`LFM_ADDR_STATUS, 32'h0, '1);
      chk(o_irq === 1'b0, "irq stuck");
    end
    i_brightness_nonzero <= 1'b0;
    i_fault.fb_below_uvp <= 1'b1;
    repeat (OCP - 4) @(posedge i_clk);
    i_fault.fb_below_uvp <= 1'b0;
    rd(`LFM_ADDR_STATUS, 32'h0, 32'h400);
    chk(o_state === LFM_RUN, "early trip");
    i_fault.fb_below_uvp <= 1'b1;
    repeat (OCP + 4) @(negedge i_clk);
    chk(o_state === LFM_RECOVERY, "no trip");
    @(posedge i_clk);
    i_fault.fb_below_uvp <= 1'b0;
    rd(`LFM_ADDR_STATUS, 32'h400, 32'h400);
    chk(o_irq === 1'b1, "trip irq");
    repeat (RC + 5) @(negedge i_clk);
    chk(o_state === LFM_HOLD, "restart at zero brightness");
    @(posedge i_clk);
    i_brightness_nonzero <= 1'b1;
    wait_st(LFM_RUN, 50);
    summarize();
  end
endmodule : testbench
